// [rtl/lcp_device.sv]
// lcd driver command port: two-wire slave, command decode and display ram
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module lcp_device
  import lcp_pkg::*;
(
  lcp_link_if.dev          link,
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic [5:0]  i_scan_addr,
  output logic      [7:0]  o_scan_data,
  output logic             o_duty,
  output logic             o_bias,
  output logic             o_osc_on,
  output logic             o_display_on,
  output logic      [3:0]  o_trim_code
);
  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    logic [2:0]                scl_s;      // sync stages 0,1 and previous
    logic [2:0]                sda_s;      // sync stages 0,1 and previous
    lcp_dev_state_t            state;      // protocol state
    logic [3:0]                bitcnt;     // bits of current byte
    logic [7:0]                sh;         // shift register
    logic [1:0]                bytecnt;    // 0 addr, 1 cmd, 2 setting, 3 data
    logic                      rw;         // current direction
    logic [7:0]                cmd;        // latched command byte
    logic [5:0]                ptr;        // ram address pointer
    logic                      incr_pend;  // bump pointer after ack clock
    logic                      macked;     // master acked sent byte
    logic                      duty;       // eighth duty when set
    logic                      bias;       // quarter bias when set
    logic                      osc;        // oscillator enable
    logic                      disp;       // display enable bit
    logic                      lcd_on;     // display really on
    logic [3:0]                trim;       // supply trim code
    logic                      sda_oe;     // pull sda low
    logic [7:0]                scan;       // scan read data
    logic [RAM_WORDS-1:0][7:0] ram;        // display ram
  } lcp_dev_regs_t;

  localparam lcp_dev_regs_t DEV_RESET = '{scl_s: 3'h7, sda_s: 3'h7, state: DEV_IDLE, ptr: PTR_RESET,
                                          duty: DUTY_RESET, bias: BIAS_RESET, osc: OSC_RESET,
                                          disp: DISP_RESET, trim: TRIM_RESET, default: '0};

  lcp_dev_regs_t r;       // registered state
  lcp_dev_regs_t next_r;  // next state

  // ****************************************
  // helpers
  // ****************************************
  // pointer step with wrap at the duty's last location
  function automatic logic [5:0] ptr_step(input logic [5:0] p, input logic duty);
    logic [5:0] top;
    top = duty ? PTR_TOP_EIGHTH : PTR_TOP_QUARTER;
    return (p >= top) ? 6'h00 : 6'(p + 6'h01);
  endfunction

  // ram read, locations beyond the array read zero
  function automatic logic [7:0] ram_rd(input logic [RAM_WORDS-1:0][7:0] m, input logic [5:0] p);
    return (int'(p) < RAM_WORDS) ? m[p] : 8'h00;
  endfunction

  // ram bytes at and one step past the pointer, named so single bits can be picked
  logic [7:0] rd_here;   // byte at the pointer
  logic [7:0] rd_after;  // byte after the pointer steps
  assign rd_here  = ram_rd(r.ram, r.ptr);
  assign rd_after = ram_rd(r.ram, ptr_step(r.ptr, r.duty));

  logic scl_rise;  // scl edges on synced level
  logic scl_fall;
  logic got_start;
  logic got_stop;
  assign scl_rise  = r.scl_s[1] & ~r.scl_s[2];
  assign scl_fall  = ~r.scl_s[1] & r.scl_s[2];
  assign got_start = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[1] & r.sda_s[2];
  assign got_stop  = r.scl_s[1] & r.scl_s[2] & r.sda_s[1] & ~r.sda_s[2];

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_r = r;
    // stage 0 feeds stage 1 only, stage 1 feeds edge detect
    next_r.scl_s = {r.scl_s[1], r.scl_s[0], link.scl};
    next_r.sda_s = {r.sda_s[1], r.sda_s[0], link.sda};
    next_r.scan  = ram_rd(r.ram, i_scan_addr);
    if (got_start) begin
      next_r.state   = DEV_RX;
      next_r.bitcnt  = 4'h0;
      next_r.bytecnt = 2'h0;
      next_r.sda_oe  = 1'b0;
    end else if (got_stop) begin
      // stop ends any transfer
      next_r.state  = DEV_IDLE;
      next_r.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (r.state)
        DEV_RX: begin
          next_r.sh     = {r.sh[6:0], r.sda_s[1]};
          next_r.bitcnt = 4'(r.bitcnt + 4'h1);
        end
        DEV_RACK: begin
          next_r.macked = ~r.sda_s[1];
        end
        default: begin
          next_r.macked = r.macked;
        end
      endcase
    end else if (scl_fall) begin
      // outputs change only while scl low
      case (r.state)
        DEV_RX: begin
          if (r.bitcnt == BITS_PER_BYTE) begin
            if (r.bytecnt == 2'h0) begin
              if (r.sh[7:1] == SLAVE_ADDR) begin
                next_r.rw     = (r.sh[0] == RW_READ);
                next_r.sda_oe = 1'b1;
                next_r.state  = DEV_ACK;
              end else begin
                next_r.state = DEV_IDLE;
              end
            end else begin
              next_r.sda_oe    = 1'b1;
              next_r.state     = DEV_ACK;
              next_r.incr_pend = 1'b0;
              if (r.bytecnt == 2'h1) begin
                next_r.cmd = r.sh;
              end else if (r.bytecnt == 2'h2) begin
                if (r.cmd == CMD_DATA) begin
                  next_r.ptr = r.sh[5:0];
                end else if (r.cmd == CMD_DRIVE) begin
                  next_r.duty = r.sh[DUTY_BIT];
                  next_r.bias = r.sh[BIAS_BIT];
                end else if (r.cmd == CMD_SYSTEM) begin
                  next_r.osc  = r.sh[OSC_BIT];
                  next_r.disp = r.sh[DISP_BIT];
                end else if (r.cmd == CMD_TRIM) begin
                  next_r.trim = r.sh[3:0];
                end
              end else if (r.cmd == CMD_DATA) begin
                if (int'(r.ptr) < RAM_WORDS) begin
                  next_r.ram[r.ptr] = r.sh;
                end
                next_r.incr_pend = 1'b1;
              end
            end
          end
        end
        DEV_ACK: begin
          // end of ack clock
          next_r.sda_oe    = 1'b0;
          next_r.bitcnt    = 4'h0;
          next_r.incr_pend = 1'b0;
          next_r.bytecnt   = (r.bytecnt == 2'h3) ? 2'h3 : 2'(r.bytecnt + 2'h1);
          if (r.incr_pend) begin
            next_r.ptr = ptr_step(r.ptr, r.duty);
          end
          if (r.rw) begin
            next_r.sh     = rd_here;
            next_r.sda_oe = ~rd_here[7];
            next_r.state  = DEV_TX;
          end else begin
            next_r.state = DEV_RX;
          end
        end
        DEV_TX: begin
          if (r.bitcnt == 4'(BITS_PER_BYTE - 4'h1)) begin
            // release for master ack
            next_r.sda_oe = 1'b0;
            next_r.state  = DEV_RACK;
          end else begin
            next_r.bitcnt = 4'(r.bitcnt + 4'h1);
            next_r.sh     = {r.sh[6:0], 1'b0};
            next_r.sda_oe = ~r.sh[6];
          end
        end
        DEV_RACK: begin
          if (r.macked) begin
            next_r.ptr    = ptr_step(r.ptr, r.duty);
            next_r.sh     = rd_after;
            next_r.sda_oe = ~rd_after[7];
            next_r.bitcnt = 4'h0;
            next_r.state  = DEV_TX;
          end else begin
            // nack: wait for stop or restart
            next_r.state = DEV_IDLE;
          end
        end
        default: begin
          next_r.sda_oe = 1'b0;
        end
      endcase
    end
    next_r.lcd_on = next_r.osc & next_r.disp;
  end

  // ****************************************
  // state register
  // ****************************************
  // reset drive configuration
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r <= DEV_RESET;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the record
  assign link.dev_sda_oe = r.sda_oe;
  assign o_scan_data     = r.scan;
  assign o_duty          = r.duty;
  assign o_bias          = r.bias;
  assign o_osc_on        = r.osc;
  assign o_display_on    = r.lcd_on;
  assign o_trim_code     = r.trim;
endmodule
`default_nettype wire

// [rtl/lcp_pkg.sv]
// constants and types shared by both ends of the lcd command port link
package lcp_pkg;
  // ****************************************
  // link protocol constants
  // ****************************************
  localparam logic [6:0] SLAVE_ADDR      = 7'h3e;  // fixed slave address
  localparam logic       RW_READ         = 1'h1;   // direction bit value for read
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;   // data bits before ack
  // ****************************************
  // commands and fields
  // ****************************************
  localparam logic [7:0] CMD_DATA        = 8'h80;  // display data access
  localparam logic [7:0] CMD_DRIVE       = 8'h82;  // duty and bias
  localparam logic [7:0] CMD_SYSTEM      = 8'h84;  // oscillator and display
  localparam logic [7:0] CMD_TRIM        = 8'h8a;  // supply trim code
  localparam int         DUTY_BIT        = 1;      // setting bit for duty
  localparam int         BIAS_BIT        = 0;      // setting bit for bias
  localparam int         OSC_BIT         = 1;      // setting bit for oscillator
  localparam int         DISP_BIT        = 0;      // setting bit for display
  localparam logic [5:0] PTR_TOP_QUARTER = 6'h1b;  // last location, quarter duty
  localparam logic [5:0] PTR_TOP_EIGHTH  = 6'h33;  // last location, eighth duty
  localparam int         RAM_WORDS       = 52;     // display ram bytes
  localparam logic [5:0] PTR_RESET       = 6'h00;  // pointer after reset
  localparam logic       DUTY_RESET      = 1'h0;   // quarter duty
  localparam logic       BIAS_RESET      = 1'h0;   // third bias
  localparam logic       OSC_RESET       = 1'h0;   // oscillator off
  localparam logic       DISP_RESET      = 1'h0;   // display off
  localparam logic [3:0] TRIM_RESET      = 4'h0;   // full supply ratio
  // ****************************************
  // host timing and registers
  // ****************************************
  localparam int         CLK_PERIOD_NS   = 40;     // system clock period
  localparam int         SCL_PERIOD_NS   = 10000;  // serial clock period
  localparam int         QUARTER_CYCLES  = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] HOST_CTRL_ADDR  = 8'h00;  // launch an operation
  localparam logic [7:0] HOST_TX_ADDR    = 8'h04;  // byte to send
  localparam logic [7:0] HOST_STAT_ADDR  = 8'h08;  // busy, ack, received byte
  localparam int         CTRL_START      = 0;      // start before the byte
  localparam int         CTRL_STOP       = 1;      // stop after the byte
  localparam int         CTRL_READ       = 2;      // read a byte instead of sending
  localparam int         CTRL_NACK       = 3;      // answer a read byte with nack
  localparam int         CTRL_NOBYTE     = 4;      // skip the byte
  localparam int         STAT_BUSY       = 0;      // operation running
  localparam int         STAT_ACK        = 1;      // slave acknowledged last byte
  localparam int         STAT_RX_LSB     = 8;      // received byte position
  // ****************************************
  // state enumerations
  // ****************************************
  typedef enum logic [2:0] {DEV_IDLE, DEV_RX, DEV_ACK, DEV_TX, DEV_RACK} lcp_dev_state_t;
  typedef enum logic [1:0] {HOST_IDLE, HOST_START, HOST_BIT, HOST_STOP} lcp_host_state_t;
endpackage

// [rtl/lcp_link_if.sv]
// open-drain two-wire link between host controller and lcd command port
`timescale 1ns/1ns
`default_nettype none
interface lcp_link_if;
  logic scl_oe;       // host pulls scl low
  logic host_sda_oe;  // host pulls sda low
  logic dev_sda_oe;   // device pulls sda low
  logic scl;          // resolved wire level
  logic sda;          // resolved wire level
  // wired-and with pull-ups
  assign scl = ~scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport host (output scl_oe, output host_sda_oe, input scl, input sda);
  modport dev  (output dev_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// [rtl/lcp_host.sv]
// host end: ahb-lite register slave driving a two-wire bus master
`timescale 1ns/1ns
`default_nettype none
module lcp_host
  import lcp_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES  // clocks per quarter scl period
)(
  lcp_link_if.host          link,
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  input  wire logic         i_hsel,
  input  wire logic [31:0]  i_haddr,
  input  wire logic [1:0]   i_htrans,
  input  wire logic         i_hwrite,
  input  wire logic [2:0]   i_hsize,
  input  wire logic [31:0]  i_hwdata,
  input  wire logic         i_hready,
  output logic      [31:0]  o_hrdata,
  output logic              o_hreadyout,
  output logic              o_hresp
);
  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    lcp_host_state_t state;    // sequencer state
    logic [7:0]      qcnt;     // quarter period counter
    logic [1:0]      phase;    // quarter within bit
    logic [3:0]      bitn;     // bit within byte, 8 is ack
    logic [4:0]      ctl;      // latched operation
    logic [7:0]      tx;       // byte to send
    logic [7:0]      rx;       // byte received
    logic            acked;    // slave ack seen
    logic            scl_oe;   // pull scl low
    logic            sda_oe;   // pull sda low
    logic [1:0]      sda_s;    // sda synchroniser
    logic            wr_pend;  // write data phase pending
    logic [7:0]      wr_addr;  // write address
    logic [31:0]     hrdata;   // read data
    logic            ready;    // bus ready
  } lcp_host_regs_t;

  lcp_host_regs_t r;       // registered state
  lcp_host_regs_t next_r;  // next state

  // level to pull on the line for bit n (1 = pull low)
  function automatic logic bit_pull(input logic [4:0] ctl, input logic [7:0] tx, input logic [3:0] n);
    if (n < BITS_PER_BYTE) begin
      return ctl[CTRL_READ] ? 1'b0 : ~tx[3'(7 - n)];
    end
    return ctl[CTRL_READ] ? ~ctl[CTRL_NACK] : 1'b0;
  endfunction

  logic [31:0] status;  // status word
  assign status = {16'h0000, r.rx, 6'h00, r.acked, (r.state != HOST_IDLE)};

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_r         = r;
    next_r.sda_s   = {r.sda_s[0], link.sda};
    next_r.ready   = 1'b1;
    next_r.wr_pend = 1'b0;
    // ahb address phase
    if (i_hready && i_hsel && i_htrans[1]) begin
      next_r.wr_pend = i_hwrite;
      next_r.wr_addr = i_haddr[7:0];
      if (!i_hwrite) begin
        if (i_haddr[7:0] == HOST_TX_ADDR) begin
          next_r.hrdata = {24'h000000, r.tx};
        end else if (i_haddr[7:0] == HOST_STAT_ADDR) begin
          next_r.hrdata = status;
        end else begin
          next_r.hrdata = 32'h00000000;
        end
      end
    end
    // bit engine, one step per quarter period
    if (r.state != HOST_IDLE) begin
      next_r.qcnt = 8'(r.qcnt + 8'h01);
      if (int'(r.qcnt) == QUARTER - 1) begin
        next_r.qcnt  = 8'h00;
        next_r.phase = 2'(r.phase + 2'h1);
        case (r.state)
          HOST_START: begin
            if (r.phase == 2'h0) next_r.scl_oe = 1'b0;
            if (r.phase == 2'h1) next_r.sda_oe = 1'b1;
            if (r.phase == 2'h2) next_r.scl_oe = 1'b1;
            if (r.phase == 2'h3) begin
              next_r.state  = r.ctl[CTRL_NOBYTE] ? (r.ctl[CTRL_STOP] ? HOST_STOP : HOST_IDLE) : HOST_BIT;
              next_r.sda_oe = r.ctl[CTRL_NOBYTE] ? r.ctl[CTRL_STOP] : bit_pull(r.ctl, r.tx, 4'h0);
              next_r.bitn   = 4'h0;
            end
          end
          HOST_BIT: begin
            if (r.phase == 2'h0) next_r.scl_oe = 1'b0;
            if (r.phase == 2'h1) begin
              if (r.bitn < BITS_PER_BYTE) next_r.rx = {r.rx[6:0], r.sda_s[1]};
              else if (!r.ctl[CTRL_READ]) next_r.acked = ~r.sda_s[1];
            end
            if (r.phase == 2'h2) next_r.scl_oe = 1'b1;
            if (r.phase == 2'h3) begin
              next_r.bitn = 4'(r.bitn + 4'h1);
              if (r.bitn == BITS_PER_BYTE) begin
                next_r.state  = r.ctl[CTRL_STOP] ? HOST_STOP : HOST_IDLE;
                next_r.sda_oe = r.ctl[CTRL_STOP];
              end else begin
                next_r.sda_oe = bit_pull(r.ctl, r.tx, 4'(r.bitn + 4'h1));
              end
            end
          end
          default: begin
            // stop: sda rises while scl high
            if (r.phase == 2'h0) next_r.scl_oe = 1'b0;
            if (r.phase == 2'h1) next_r.sda_oe = 1'b0;
            if (r.phase == 2'h3) next_r.state = HOST_IDLE;
          end
        endcase
      end
    end
    // ahb data phase writes
    if (r.wr_pend) begin
      if (r.wr_addr == HOST_TX_ADDR) begin
        next_r.tx = i_hwdata[7:0];
      end else if (r.wr_addr == HOST_CTRL_ADDR && r.state == HOST_IDLE) begin
        next_r.ctl   = i_hwdata[4:0];
        next_r.qcnt  = 8'h00;
        next_r.phase = 2'h0;
        next_r.bitn  = 4'h0;
        if (i_hwdata[CTRL_START]) begin
          next_r.state  = HOST_START;
          next_r.sda_oe = 1'b0;
        end else if (!i_hwdata[CTRL_NOBYTE]) begin
          next_r.state  = HOST_BIT;
          next_r.sda_oe = bit_pull(i_hwdata[4:0], r.tx, 4'h0);
        end else if (i_hwdata[CTRL_STOP]) begin
          next_r.state  = HOST_STOP;
          next_r.sda_oe = 1'b1;
        end
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r <= '{state: HOST_IDLE, sda_s: 2'h3, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign link.scl_oe      = r.scl_oe;
  assign link.host_sda_oe = r.sda_oe;
  assign o_hrdata         = r.hrdata;
  assign o_hreadyout      = r.ready;
  assign o_hresp          = 1'b0;
endmodule
`default_nettype wire

// [tb/lcp_link_props.sv]
// assertions on the two-wire link between host and lcd command port
`timescale 1ns/1ns
`default_nettype none
module lcp_link_props (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ****************************************
  // scl falls counted since the last start
  // ****************************************
  logic       sda_q;  // sda one clock back
  logic [3:0] falls;  // saturating fall count
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sda_q <= 1'b1;
      falls <= 4'hf;
    end else begin
      sda_q <= sda;
      // start restarts the count
      if (scl && sda_q && !sda) begin
        falls <= 4'h0;
      end else if ($fell(scl) && falls != 4'hf) begin
        falls <= falls + 4'h1;
      end
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  AST_DEV_LOW_EDGE: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved sda while scl high");
  AST_ADDR_SILENT: assert property (falls < 4'h9 |-> !dev_sda_oe)
    else $error("device drove sda during the address byte");
  AST_ACK_HELD: assert property (dev_sda_oe && $rose(scl) |-> dev_sda_oe [*8])
    else $error("device let go of sda inside scl high");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  AST_SCL_LOW: assert property ($rose(scl_oe) |-> scl_oe [*8])
    else $error("scl low phase too short");
  AST_START_FRAME: assert property (scl && $past(scl) && $rose(host_sda_oe) |-> ##[1:8] !scl)
    else $error("no scl fall after start");
  AST_STOP_RELEASE: assert property (scl && $past(scl) && $fell(host_sda_oe) |-> !dev_sda_oe [*8])
    else $error("device holds sda around stop");
  AST_STOP_IDLE: assert property (scl && $past(scl) && $fell(host_sda_oe) |=> scl [*3])
    else $error("scl dropped right after stop");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench joining the host controller and the lcd command port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import lcp_pkg::*;
  localparam logic [4:0] S = 5'h01, P = 5'h02, R = 5'h04, N = 5'h08, B = 5'h10;  // ctrl bits
  localparam logic [7:0] WA = {SLAVE_ADDR, 1'b0};     // address byte, write
  localparam logic [7:0] RA = {SLAVE_ADDR, RW_READ};  // address byte, read
  localparam logic [7:0] CMDS [7] = '{8'h82, 8'h84, 8'h84, 8'h84, 8'h8a, 8'h86, 8'h82};
  localparam logic [7:0] VALS [7] = '{8'h02, 8'h01, 8'h02, 8'h03, 8'h05, 8'h03, 8'h01};
  localparam logic [7:0] EXPS [7] = '{8'h80, 8'h80, 8'ha0, 8'hb0, 8'hb5, 8'hb5, 8'h75};
  logic        clk = 1'b0;      // system clock
  logic        rst = 1'b1;      // async reset
  logic [31:0] haddr = 32'h0;   // ahb address
  logic [1:0]  htrans = 2'h0;   // ahb transfer kind
  logic        hwrite = 1'b0;   // ahb direction
  logic [31:0] hwdata = 32'h0;  // ahb write data
  logic [5:0]  scan = 6'h0;     // ram scan address
  logic [31:0] rd;              // last read word
  wire logic [31:0] hrdata;     // ahb read data
  wire logic        hready;     // ahb ready
  wire logic        hresp;      // ahb response
  wire logic [7:0]  scan_data;  // ram scan data
  wire logic [7:0]  cfg;        // duty, bias, osc, display, trim
  int          miscompares = 0;
  int          comparisons = 0;
  lcp_link_if link();
  lcp_host #(.QUARTER(4)) lcp_host_i (.link(link), .i_clock(clk), .i_rst(rst), .i_hsel(1'b1), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp));
  lcp_device lcp_device_i (.link(link), .i_clock(clk), .i_rst(rst), .i_scan_addr(scan), .o_scan_data(scan_data),
    .o_duty(cfg[7]), .o_bias(cfg[6]), .o_osc_on(cfg[5]), .o_display_on(cfg[4]), .o_trim_code(cfg[3:0]));
  lcp_link_props lcp_link_props_i (.i_clock(clk), .i_rst(rst), .scl_oe(link.scl_oe), .host_sda_oe(link.host_sda_oe),
    .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
  // 25 MHz clock
  always #20 clk = ~clk;
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one ahb single transfer, held until hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // one link byte, then poll until idle
  task automatic op(input logic [4:0] c, input logic [7:0] t);
    ahb(1'b1, HOST_TX_ADDR, {24'h0, t});
    ahb(1'b1, HOST_CTRL_ADDR, {27'h0, c});
    do ahb(1'b0, HOST_STAT_ADDR, 32'h0); while (rd[STAT_BUSY] !== 1'b0);
  endtask
  task automatic ptr(input logic [7:0] p);
    op(S, WA);
    op(5'h0, CMD_DATA);
    op(5'h0, p);
  endtask
  task automatic peek(input logic [5:0] a, input logic [7:0] e);
    scan <= a;
    repeat (2) @(posedge clk);
    chk({24'h0, scan_data}, {24'h0, e});
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    chk({24'h0, cfg}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    ahb(1'b1, HOST_TX_ADDR, 32'h0000005a);
    ahb(1'b0, HOST_TX_ADDR, 32'h0);
    chk(rd, 32'h0000005a);
    $display("test reset done");
    op(S, WA ^ 8'h02);
    chk({31'h0, rd[STAT_ACK]}, 32'h0);
    op(P | B, 8'h00);
    $display("test foreign address done");
    for (int i = 0; i < 7; i++) begin
      op(S, WA);
      op(5'h0, CMDS[i]);
      op(P, VALS[i]);
      chk({31'h0, rd[STAT_ACK]}, 32'h1);
      chk({24'h0, cfg}, {24'h0, EXPS[i]});
    end
    $display("test settings done");
    ptr(8'h1a);
    for (int i = 0; i < 4; i++) op((i == 3) ? P : 5'h0, 8'ha1 + 8'(i));
    peek(6'h1a, 8'ha1);
    peek(6'h1b, 8'ha2);
    peek(6'h00, 8'ha3);
    peek(6'h01, 8'ha4);
    $display("test page write done");
    ptr(8'h1b);
    op(S, RA);
    chk({31'h0, rd[STAT_ACK]}, 32'h1);
    op(R, 8'h00);
    chk({24'h0, rd[15:8]}, 32'ha2);
    op(R, 8'h00);
    chk({24'h0, rd[15:8]}, 32'ha3);
    op(R | N | P, 8'h00);
    chk({24'h0, rd[15:8]}, 32'ha4);
    op(S, RA);
    op(R | N | P, 8'h00);
    chk({24'h0, rd[15:8]}, 32'ha4);
    $display("test read done");
    op(S, WA);
    op(5'h0, CMD_DRIVE);
    op(P, 8'h02);
    ptr(8'h33);
    op(5'h0, 8'hc1);
    op(P, 8'hc2);
    peek(6'h33, 8'hc1);
    peek(6'h00, 8'hc2);
    $display("test eighth duty wrap done");
    results();
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
